// ===== pic_top.sv
/*
  priority interrupt controller register and arbitration logic.
  assumes one AHB-Lite master, sources and trap events in the hclk domain,
  external pins asynchronous.
*/
// Chosen here: the register offsets and register access over AHB-Lite.
// Overview of operation
// - each source flag is set by hardware and cleared only by software writes
// - each source has its own independent enable bit
// - each user source gets a 3-bit priority, eight levels
// - flags, enables, priorities packed in natural order, source 0 at bit 0
// - pending register latches vector in 7:0 and level in 11:8
// - vector 4 math, 5 dma, 6 soft trap, user sources start at 8
// - cpu level is high bit plus 3-bit field; high bit blocks user interrupts
// - level field 7 blocks all user interrupts
// - software cannot set the level-high bit; traps raise it
// - software writes change the level field unless nesting is disabled
// - trap status flags are set when their trap occurs
// - global enable resets to one; clearing it stops delivery
// - software trap bit 13 of global control is writable and reads back but drives no logic
// - external edge polarity: one is falling edge, zero rising edge
// - soft trap flags for dma address error and loop stack overflow
// - hard trap register holds the soft hard trap flag in bit 0 only
// - core control bit 15 selects variable latency, resets fixed
// - equal priority ties go to the lower natural order source
// - all requests merge into one request to the core
`timescale 1ns/100ps
module pic_top
  import pic_pkg::*;
#(
  parameter int NUM_SRC = 32
)
(
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite slave
  input  wire pic_pkg::pic_ahb_req_t ahb_req,
  input  wire logic [31:0]           hwdata,
  output pic_pkg::pic_ahb_rsp_t      ahb_rsp,
  // interrupt sources
  input  wire logic [NUM_SRC-1:0]    src_event,
  input  wire logic [2:0]            ext_pin,
  input  wire logic [15:0]           trap_event,
  input  wire logic [1:0]            soft_trap_event,
  input  wire logic                  hard_trap_event,
  // core handshake
  input  wire logic                  irq_ack,
  input  wire logic                  irq_return,
  input  wire logic                  trap_entry,
  output logic                       cpu_irq,
  output logic                       nesting_disable,
  output logic                       var_latency
);
  import pic_pkg::*;

  localparam int WORDS = (NUM_SRC + 15) / 16;
  localparam int PWORDS = (NUM_SRC + 3) / 4;

  if (NUM_SRC < 3 || NUM_SRC > 128)
  begin : g_bad_num_src
    $error("NUM_SRC out of range");
  end

  // bus state
  logic        dp_wr;
  logic        dp_rd;
  logic [7:0]  dp_addr;
  logic [15:0] wdat;
  logic [15:0] rdat;

  // registers
  logic [2:0]         cpu_level_low;
  logic               cpu_level_high;
  logic [15:0]        trap_ctrl;
  logic [15:0]        global_ctrl;
  logic [15:0]        soft_trap;
  logic               soft_hard_trap_flag;
  logic [7:0]         pending_vector_number;
  logic [3:0]         new_cpu_level;
  logic [NUM_SRC-1:0] request_flag_words;
  logic [NUM_SRC-1:0] source_enable_words;
  logic [2:0]         source_priority_words [NUM_SRC];
  logic               in_handler;

  // external pin sync and edge detect
  logic [2:0] ext_s1;
  logic [2:0] ext_s2;
  logic [2:0] ext_s3;
  logic [2:0] ext_edge;
  logic [NUM_SRC-1:0] hw_set;

  wire logic addr_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  assign wdat = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_wr   <= addr_ok && ahb_req.hwrite;
      dp_rd   <= addr_ok && !ahb_req.hwrite;
      dp_addr <= ahb_req.haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_s1 <= 3'h0;
      ext_s2 <= 3'h0;
      ext_s3 <= 3'h0;
    end
    else
    begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // falling edge when polarity bit set, rising otherwise
  assign ext_edge = (global_ctrl[2:0] & ext_s3 & ~ext_s2) |
                    (~global_ctrl[2:0] & ~ext_s3 & ext_s2);

  always_comb
  begin
    hw_set = src_event;
    hw_set[0] = src_event[0] | ext_edge[0];
    hw_set[1] = src_event[1] | ext_edge[1];
    hw_set[2] = src_event[2] | ext_edge[2];
  end

  // per-source flag, enable and priority
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      wire logic fwr = dp_wr && dp_addr == OFS_FLAG_BASE + 8'(4 * (g / 16));
      wire logic ewr = dp_wr && dp_addr == OFS_ENABLE_BASE + 8'(4 * (g / 16));
      wire logic pwr = dp_wr && dp_addr == OFS_PRIO_BASE + 8'(4 * (g / 4));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          request_flag_words[g]    <= 1'b0;
          source_enable_words[g]   <= 1'b0;
          source_priority_words[g] <= 3'h0;
        end
        else
        begin
          if (hw_set[g])
            request_flag_words[g] <= 1'b1;
          else if (fwr)
            request_flag_words[g] <= wdat[g % 16];
          if (ewr)
            source_enable_words[g] <= wdat[g % 16];
          if (pwr)
            source_priority_words[g] <= wdat[4 * (g % 4) +: 3];
        end
      end
    end
  endgenerate

  // arbitration: highest priority, lowest index on ties
  logic [2:0]  best_prio;
  logic [7:0]  best_vec;
  logic        best_hit;
  always_comb
  begin
    best_prio = 3'h0;
    best_vec  = 8'h00;
    best_hit  = 1'b0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (request_flag_words[i] && source_enable_words[i] &&
          (!best_hit || source_priority_words[i] > best_prio))
      begin
        best_hit  = 1'b1;
        best_prio = source_priority_words[i];
        best_vec  = VEC_FIRST_USER + 8'(i);
      end
    end
  end

  wire logic [3:0] cpu_level = {cpu_level_high, cpu_level_low};
  wire logic deliver = best_hit && global_ctrl[GIE_POS] && !cpu_level_high &&
                       {1'b0, best_prio} > cpu_level &&
                       !(in_handler && trap_ctrl[NEST_DIS_POS]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cpu_irq <= 1'b0;
    else
      cpu_irq <= deliver;
  end

  // pending vector latch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pending_vector_number <= 8'h00;
      new_cpu_level         <= 4'h0;
    end
    else if (trap_entry)
    begin
      new_cpu_level <= LEVEL_TRAP;
      if (trap_event[4])
        pending_vector_number <= VEC_MATH_TRAP;
      else if (trap_event[5])
        pending_vector_number <= VEC_DMA_TRAP;
      else
        pending_vector_number <= VEC_SOFT_TRAP;
    end
    else if (deliver)
    begin
      pending_vector_number <= best_vec;
      new_cpu_level         <= {1'b0, best_prio};
    end
  end

  // cpu level and handler tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_level_low  <= 3'h0;
      cpu_level_high <= 1'b0;
      in_handler     <= 1'b0;
    end
    else
    begin
      if (trap_entry)
        cpu_level_high <= 1'b1;
      else if (irq_return)
        cpu_level_high <= 1'b0;
      if (irq_ack && !trap_entry)
        cpu_level_low <= new_cpu_level[2:0];
      else if (dp_wr && dp_addr == OFS_STATUS_WORD && !trap_ctrl[NEST_DIS_POS])
        cpu_level_low <= wdat[LEVEL_LO_POS +: 3];
      if (irq_ack)
        in_handler <= 1'b1;
      else if (irq_return)
        in_handler <= 1'b0;
    end
  end

  // control and trap status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trap_ctrl           <= RST_ZERO;
      global_ctrl         <= RST_GLOBAL_CTRL;
      soft_trap           <= RST_ZERO;
      soft_hard_trap_flag <= 1'b0;
      var_latency         <= 1'b0;
    end
    else
    begin
      if (dp_wr && dp_addr == OFS_TRAP_CTRL)
        trap_ctrl <= (wdat & MASK_TRAP_CTRL) | (trap_event & MASK_TRAP_FLAGS);
      else
        trap_ctrl <= trap_ctrl | (trap_event & MASK_TRAP_FLAGS);
      if (dp_wr && dp_addr == OFS_GLOBAL_CTRL)
        global_ctrl <= wdat & MASK_GLOBAL_CTRL;
      if (dp_wr && dp_addr == OFS_SOFT_TRAP)
        soft_trap <= (wdat | {10'h000, soft_trap_event, 4'h0}) & MASK_SOFT_TRAP;
      else
        soft_trap <= soft_trap | {10'h000, soft_trap_event, 4'h0};
      if (hard_trap_event)
        soft_hard_trap_flag <= 1'b1;
      else if (dp_wr && dp_addr == OFS_HARD_TRAP)
        soft_hard_trap_flag <= wdat[0];
      if (dp_wr && dp_addr == OFS_CORE_CONTROL)
        var_latency <= wdat[VAR_LATENCY_POS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      nesting_disable <= 1'b0;
    else
      nesting_disable <= trap_ctrl[NEST_DIS_POS];
  end

  // read mux
  always_comb
  begin
    rdat = 16'h0000;
    case (dp_addr)
      OFS_STATUS_WORD:  rdat = {8'h00, cpu_level_low, 5'h00};
      OFS_CORE_CONTROL: rdat = {var_latency, 11'h000, cpu_level_high, 3'h0};
      OFS_TRAP_CTRL:    rdat = trap_ctrl;
      OFS_GLOBAL_CTRL:  rdat = global_ctrl;
      OFS_SOFT_TRAP:    rdat = soft_trap;
      OFS_HARD_TRAP:    rdat = {15'h0000, soft_hard_trap_flag};
      OFS_PENDING:      rdat = {4'h0, new_cpu_level, pending_vector_number};
      default:
      begin
        for (int w = 0; w < WORDS; w++)
        begin
          if (dp_addr == OFS_FLAG_BASE + 8'(4 * w))
            for (int b = 0; b < 16; b++)
              if (16 * w + b < NUM_SRC)
                rdat[b] = request_flag_words[16 * w + b];
          if (dp_addr == OFS_ENABLE_BASE + 8'(4 * w))
            for (int b = 0; b < 16; b++)
              if (16 * w + b < NUM_SRC)
                rdat[b] = source_enable_words[16 * w + b];
        end
        for (int p = 0; p < PWORDS; p++)
          if (dp_addr == OFS_PRIO_BASE + 8'(4 * p))
            for (int k = 0; k < 4; k++)
              if (4 * p + k < NUM_SRC)
                rdat[4 * k +: 3] = source_priority_words[4 * p + k];
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ahb_rsp <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
    else
      // one wait state on reads so hrdata is taken from the data-phase address
      ahb_rsp <= '{hrdata: dp_rd ? {16'h0000, rdat} : ahb_rsp.hrdata,
                   hreadyout: !(addr_ok && !ahb_req.hwrite), hresp: 1'b0};
  end

  // assertions
  irq_global_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !global_ctrl[GIE_POS] |=> !cpu_irq) else $error("irq with global enable clear");
  irq_level7_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_level_low == 3'h7 |=> !cpu_irq) else $error("irq at level 7");
  irq_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_level_high |=> !cpu_irq) else $error("irq with level high set");
  flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_set[0] |=> request_flag_words[0]) else $error("flag lost");
  nest_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trap_ctrl[NEST_DIS_POS] && !irq_ack |=> $stable(cpu_level_low)) else $error("level written");
  trap_raise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trap_entry |=> cpu_level_high && new_cpu_level == LEVEL_TRAP) else $error("trap level");
  irq_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_irq |-> $past(best_hit && source_enable_words != '0)) else $error("irq without source");
  bus_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ahb_rsp.hreadyout |=> ahb_rsp.hreadyout && !ahb_rsp.hresp) else $error("bus stalled");

endmodule

// ===== pic_pkg.sv
/*
  package for the priority interrupt controller: register offsets,
  field positions, reset values, vector codes and bus carriers.
  assumes an AHB-Lite slave with 32-bit data, one word per register.
*/
package pic_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS_WORD  = 8'h00;
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TRAP_CTRL    = 8'h08;
  localparam logic [7:0] OFS_GLOBAL_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_SOFT_TRAP    = 8'h10;
  localparam logic [7:0] OFS_HARD_TRAP    = 8'h14;
  localparam logic [7:0] OFS_PENDING      = 8'h18;
  localparam logic [7:0] OFS_FLAG_BASE    = 8'h20;
  localparam logic [7:0] OFS_ENABLE_BASE  = 8'h40;
  localparam logic [7:0] OFS_PRIO_BASE    = 8'h60;

  // field positions
  localparam int LEVEL_LO_POS      = 5;
  localparam int LEVEL_HI_POS      = 3;
  localparam int VAR_LATENCY_POS   = 15;
  localparam int NEST_DIS_POS      = 15;
  localparam int GIE_POS           = 15;
  localparam int TIMED_DIS_POS     = 14;
  localparam int SW_TRAP_POS       = 13;
  localparam int PEND_LEVEL_POS    = 8;

  // writable masks, unimplemented bits ignore writes
  localparam logic [15:0] MASK_STATUS_WORD = 16'h00e0;
  localparam logic [15:0] MASK_CORE_CTRL   = 16'h8000;
  localparam logic [15:0] MASK_TRAP_CTRL   = 16'hfffe;
  localparam logic [15:0] MASK_GLOBAL_CTRL = 16'he007;
  localparam logic [15:0] MASK_SOFT_TRAP   = 16'h0030;
  localparam logic [15:0] MASK_HARD_TRAP   = 16'h0001;
  localparam logic [15:0] MASK_TRAP_FLAGS  = 16'h78fe;

  // reset values
  localparam logic [15:0] RST_GLOBAL_CTRL  = 16'h8000;
  localparam logic [15:0] RST_ZERO         = 16'h0000;

  // vector codes
  localparam logic [7:0] VEC_MATH_TRAP     = 8'h04;
  localparam logic [7:0] VEC_DMA_TRAP      = 8'h05;
  localparam logic [7:0] VEC_SOFT_TRAP     = 8'h06;
  localparam logic [7:0] VEC_FIRST_USER    = 8'h08;
  localparam logic [3:0] LEVEL_TRAP        = 4'hf;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } pic_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pic_ahb_rsp_t;

endpackage

// ===== pic_core_model.sv
/* core model: acks a raised request, returns from handlers and traps.
   assumes the controller's registered handshake on hclk. */
`timescale 1ns/100ps
module pic_core_model #(
  parameter int DLY  = 2,
  parameter int HOLD = 30
)
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // core handshake
  input  wire logic en,
  input  wire logic cpu_irq,
  input  wire logic trap_entry,
  output logic      irq_ack,
  output logic      irq_return
);
  int   cnt;
  logic tr;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt <= 0;
      tr <= 1'b0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end
    else if (cnt == 0)
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      tr <= trap_entry;
      if (trap_entry || (en && cpu_irq))
        cnt <= 1;
    end
    else
    begin
      cnt <= (cnt == HOLD) ? 0 : cnt + 1;
      irq_ack <= (cnt == DLY) && !tr;
      irq_return <= (cnt == HOLD);
    end
endmodule

// ===== pic_top_tb_top.sv
/* self-checking bench for pic_top: registers, delivery, traps, pins.
   assumes an AHB-Lite slave that may stretch data phases, core model beside it. */
`timescale 1ns/100ps
module pic_top_tb_top;
  import pic_pkg::*;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  pic_ahb_req_t m = '0;
  pic_ahb_req_t req;
  pic_ahb_rsp_t ahb_rsp;
  logic [31:0]  hwdata = '0;
  logic [31:0]  src_event = '0;
  logic [2:0]   ext_pin = '0;
  logic [15:0]  trap_event = '0;
  logic [1:0]   soft_trap_event = '0;
  logic         hard_trap_event = 1'b0;
  logic         trap_entry = 1'b0;
  logic         en = 1'b0;
  logic         irq_ack, irq_return, cpu_irq, nesting_disable, var_latency, x;
  logic [15:0]  r;
  logic [7:0]   ofs [8];
  logic [15:0]  wv [8];
  logic [15:0]  rv [8];
  int           n_fail = 0;
  int           comparisons = 0;
  int           seed = 42532;
  int           i, p, k;

  assign req = {m[39:1], ahb_rsp.hreadyout};
  always #10 hclk = ~hclk;

  pic_top i_pic_top (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hwdata(hwdata), .ahb_rsp(ahb_rsp),
    .src_event(src_event), .ext_pin(ext_pin), .trap_event(trap_event), .soft_trap_event(soft_trap_event),
    .hard_trap_event(hard_trap_event), .irq_ack(irq_ack), .irq_return(irq_return),
    .trap_entry(trap_entry), .cpu_irq(cpu_irq), .nesting_disable(nesting_disable), .var_latency(var_latency));
  pic_core_model i_pic_core_model (.hclk(hclk), .hresetn(hresetn), .en(en), .cpu_irq(cpu_irq),
    .trap_entry(trap_entry), .irq_ack(irq_ack), .irq_return(irq_return));

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: reg %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // bounded wait for hready, data taken at the falling edge before the closing edge
  task automatic ready_wait;
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
    end
    while (ahb_rsp.hreadyout !== 1'b1 && n < 20);
    if (ahb_rsp.hreadyout !== 1'b1)
    begin
      n_fail++;
      $display("unexpected at %0t: bus timeout", $time);
      tally_and_finish;
    end
    r = ahb_rsp.hrdata[15:0];
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    m <= '{{24'h0, a}, 2'b10, w, 3'h2, 1'b1, 1'b1};
    ready_wait;
    m.htrans <= 2'b00;
    hwdata <= {16'h0, d};
    ready_wait;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0);
    chk_reg(r, exp);
  endtask

  task automatic irq_is(input logic e);
    tick(2);
    @(negedge hclk);
    chk_pin(cpu_irq, e);
    @(posedge hclk);
  endtask

  task automatic fire(input logic [31:0] s);
    src_event <= s;
    tick(1);
    src_event <= '0;
  endtask

  initial
  begin
    ofs = '{OFS_STATUS_WORD, OFS_CORE_CONTROL, OFS_GLOBAL_CTRL, OFS_SOFT_TRAP, OFS_HARD_TRAP,
      OFS_TRAP_CTRL, OFS_PENDING, 8'hfc};
    wv = '{16'h00e0, 16'h8000, 16'he007, 16'h0030, 16'h0001, 16'hfffe, 16'h0, 16'h0};
    rv = '{16'h0, 16'h0, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    tick(3);
    hresetn <= 1'b1;
    for (k = 0; k < 8; k++)
    begin
      rd(ofs[k], rv[k]);
      wr(ofs[k], 16'hffff);
      rd(ofs[k], wv[k]);
      if (k == 1) chk_pin(var_latency, 1'b1);
      if (k == 5) chk_pin(nesting_disable, 1'b1);
      wr(ofs[k], rv[k]);
    end
    wr(OFS_TRAP_CTRL, 16'h8000);
    wr(OFS_STATUS_WORD, 16'h00e0);
    rd(OFS_STATUS_WORD, 16'h0);
    wr(OFS_TRAP_CTRL, 16'h0);
    for (k = 0; k < 8; k++)
    begin
      i = (k < 2) ? k * 31 : $unsigned($random(seed)) % 32;
      p = (k == 2) ? 0 : 1 + $unsigned($random(seed)) % 7;
      x = (k != 3) && (p != 0);
      wr(OFS_ENABLE_BASE + 8'(4 * (i / 16)), 16'(k != 3) << (i % 16));
      wr(OFS_PRIO_BASE + 8'(4 * (i / 4)), 16'(p) << (4 * (i % 4)));
      fire(32'h1 << i);
      irq_is(x);
      rd(OFS_FLAG_BASE + 8'(4 * (i / 16)), 16'h1 << (i % 16));
      if (x) rd(OFS_PENDING, {4'h0, 4'(p), 8'(8 + i)});
      wr(OFS_FLAG_BASE + 8'(4 * (i / 16)), 16'h0);
      rd(OFS_FLAG_BASE + 8'(4 * (i / 16)), 16'h0);
      wr(OFS_ENABLE_BASE + 8'(4 * (i / 16)), 16'h0);
    end
    wr(OFS_ENABLE_BASE, 16'h0024);
    wr(OFS_PRIO_BASE, 16'h0400);
    wr(OFS_PRIO_BASE + 8'h04, 16'h0040);
    fire(32'h24);
    irq_is(1'b1);
    rd(OFS_PENDING, 16'h040a);
    for (k = 0; k < 3; k++)
    begin
      wr(OFS_STATUS_WORD, {8'h0, 3'((k == 0) ? 7 : k + 2), 5'h0});
      irq_is(k == 1);
    end
    wr(OFS_STATUS_WORD, 16'h0);
    wr(OFS_GLOBAL_CTRL, 16'h0);
    irq_is(1'b0);
    wr(OFS_GLOBAL_CTRL, 16'h8000);
    for (k = 0; k < 3; k++)
    begin
      trap_event <= (k < 2) ? 16'h10 << k : 16'h0;
      trap_entry <= 1'b1;
      tick(1);
      trap_event <= '0;
      trap_entry <= 1'b0;
      irq_is(1'b0);
      rd(OFS_PENDING, 16'h0f04 + 16'(k));
      rd(OFS_TRAP_CTRL, (k < 2) ? 16'h10 << k : 16'h0);
      wr(OFS_TRAP_CTRL, 16'h0);
      tick(35);
      irq_is(1'b1);
    end
    wr(OFS_FLAG_BASE, 16'h0);
    wr(OFS_ENABLE_BASE, 16'h0);
    i = $random(seed);
    trap_event <= 16'(i);
    soft_trap_event <= 2'b11;
    hard_trap_event <= 1'b1;
    tick(1);
    trap_event <= '0;
    soft_trap_event <= '0;
    hard_trap_event <= 1'b0;
    rd(OFS_TRAP_CTRL, 16'(i) & 16'h78fe);
    rd(OFS_SOFT_TRAP, 16'h0030);
    rd(OFS_HARD_TRAP, 16'h0001);
    wr(OFS_TRAP_CTRL, 16'h0);
    for (k = 0; k < 3; k++)
    begin
      if (k == 1) wr(OFS_GLOBAL_CTRL, 16'h8007);
      ext_pin <= (k == 1) ? 3'h0 : 3'h7;
      tick(6);
      rd(OFS_FLAG_BASE, (k < 2) ? 16'h0007 : 16'h0);
      wr(OFS_FLAG_BASE, 16'h0);
    end
    wr(OFS_TRAP_CTRL, 16'h8000);
    wr(OFS_ENABLE_BASE, 16'h000a);
    wr(OFS_PRIO_BASE, 16'h5020);
    en <= 1'b1;
    fire(32'h2);
    for (k = 0; k < 20 && irq_ack !== 1'b1; k++) @(negedge hclk);
    chk_pin(irq_ack, 1'b1);
    if (irq_ack !== 1'b1) tally_and_finish;
    @(posedge hclk);
    en <= 1'b0;
    fire(32'h8);
    irq_is(1'b0);
    tally_and_finish;
  end
endmodule
